/* logic/axr_defines.vh */
// constants for the auxiliary external regulator control block
`ifndef AXR_DEFINES_VH
`define AXR_DEFINES_VH

// chip operating mode encoding
`define AXR_MODE_W        3
`define AXR_MODE_INIT     3'h0
`define AXR_MODE_NORMAL   3'h1
`define AXR_MODE_STOP     3'h2
`define AXR_MODE_SLEEP    3'h3
`define AXR_MODE_RESTART  3'h4
`define AXR_MODE_FAILSAFE 3'h5

// configuration lock states
`define AXR_CFG_W         2
`define AXR_CFG_NONE      2'h0
`define AXR_CFG_STANDALONE 2'h1
`define AXR_CFG_SHARE     2'h2

// output level code: 0 is 3.3 V, 1 is 1.8 V
`define AXR_LEVEL_3V3     1'h0
`define AXR_LEVEL_1V8     1'h1

// drive path states in low-power operation
`define AXR_PATH_LOW      1'h0
`define AXR_PATH_HIGH     1'h1

// filter length of analog comparator inputs, in cycles
`define AXR_FILT_LEN      2

`endif

/* logic/axr_sticky_flag.v */
// sticky status flag: set wins over clear, clear only once cause is gone
`timescale 1ns/100ps
`default_nettype none
module axr_sticky_flag (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire set_ev,
  input  wire cause,
  input  wire clr,
  input  wire block,
  output reg  flag_r
);
  reg flag_nxt;

  always @* begin
    flag_nxt = flag_r;
    if (clr && !cause) begin
      flag_nxt = 1'b0;
    end
    // set beats a clear arriving in the same cycle
    if (set_ev) begin
      flag_nxt = 1'b1;
    end
    if (block) begin
      flag_nxt = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end
endmodule
`default_nettype wire

/* logic/axr_filter.v */
// short majority-free filter for an analog comparator level
`include "axr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module axr_filter #(
  parameter LEN = `AXR_FILT_LEN
) (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire din,
  output reg  dout_r
);
  reg [LEN-1:0] hist_r;
  wire          all_one;
  wire          all_zero;

  assign all_one  = &hist_r;
  assign all_zero = ~|hist_r;

  // a level must hold LEN cycles before it is believed
  always @(posedge clk) begin
    if (rst) begin
      hist_r <= {LEN{1'b0}};
      dout_r <= 1'b0;
    end else if (ce) begin
      hist_r <= {hist_r[LEN-2:0], din};
      if (all_one) begin
        dout_r <= 1'b1;
      end else if (all_zero) begin
        dout_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/axr_ctrl.v */
// configuration lock and enable control of the auxiliary external regulator
`include "axr_defines.vh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - stand-alone: select bit 0 gives 3.3 V, 1 gives 1.8 V
// - load sharing locked: voltage select bit is ignored
// - on bit in normal mode, share bit clear, locks stand-alone
// - first share bit set locks load sharing; on bit then unused
// - chosen configuration stays fixed through soft reset
// - stand-alone locked: share request silently rejected, no fail flag
// - sharing locked: any change request raises spi fail flag
// - stand-alone locked: on bit written in normal mode still turns regulator on and off
// - regulator state follows operating mode per configuration
// - stop mode drops sharing unless keep bit set; resumes in normal
// - battery undervoltage turns regulator off unless keep bit set
// - stand-alone overcurrent sets flag; clear only when cause gone
// - stand-alone undervoltage sets undervoltage flag
// - load sharing never signals undervoltage
// - load sharing never sets overcurrent flag
// - load sharing shuts down in fail-safe mode
// - stop mode: high-power path follows base current hysteresis
// - normal mode: only the high-power path may be active
module axr_ctrl #(
  parameter FILT_LEN = `AXR_FILT_LEN
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   soft_rst,
  input  wire                   ce,
  input  wire [`AXR_MODE_W-1:0] op_mode,
  input  wire                   cfg_wr,
  input  wire                   aux_standalone_on,
  input  wire                   aux_load_share_enable,
  input  wire                   aux_voltage_select,
  input  wire                   aux_share_keep_in_stop,
  input  wire                   aux_keep_on_supply_low,
  input  wire                   battery_low,
  input  wire                   shunt_over,
  input  wire                   aux_out_low,
  input  wire                   base_above_upper,
  input  wire                   base_below_lower,
  input  wire                   oc_clr,
  input  wire                   uv_clr,
  output reg  [`AXR_CFG_W-1:0]  cfg_state_r,
  output reg                    reg_enable_r,
  output reg                    level_1v8_r,
  output reg                    high_path_en_r,
  output reg                    low_path_en_r,
  output reg                    spi_fail_r,
  output wire                   aux_overcurrent_flag,
  output wire                   aux_undervoltage_flag
);

  // lock states and filtered comparator count
  localparam [`AXR_CFG_W-1:0] ST_NONE  = `AXR_CFG_NONE;
  localparam [`AXR_CFG_W-1:0] ST_ALONE = `AXR_CFG_STANDALONE;
  localparam [`AXR_CFG_W-1:0] ST_SHARE = `AXR_CFG_SHARE;
  localparam                  FILT_CH  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // control bits held from software writes
  reg  on_r;
  reg  share_r;
  reg  sel_r;
  reg  keep_stop_r;
  reg  keep_uv_r;
  reg  path_r;
  reg  [`AXR_CFG_W-1:0] cfg_nxt;
  reg  en_nxt;
  reg  path_nxt;
  reg  fail_nxt;

  wire is_sa;
  wire is_ls;
  wire bat_low_f;
  wire oc_f;
  wire uv_f;
  wire m_norm;
  wire m_stop;
  wire m_sleep;
  wire m_rst;
  wire m_init;
  wire m_fs;
  wire [FILT_CH-1:0] raw_in;
  wire [FILT_CH-1:0] filt_out;

  assign is_sa   = (cfg_state_r == ST_ALONE);
  assign is_ls   = (cfg_state_r == ST_SHARE);
  assign m_norm  = (op_mode == `AXR_MODE_NORMAL);
  assign m_stop  = (op_mode == `AXR_MODE_STOP);
  assign m_sleep = (op_mode == `AXR_MODE_SLEEP);
  assign m_rst   = (op_mode == `AXR_MODE_RESTART);
  assign m_init  = (op_mode == `AXR_MODE_INIT);
  assign m_fs    = (op_mode == `AXR_MODE_FAILSAFE);

  ////////////////////////////////////////////////////////////////////////////
  // comparator inputs filtered against glitches
  assign raw_in = {aux_out_low, shunt_over, battery_low};

  genvar gi;
  generate
    for (gi = 0; gi < FILT_CH; gi = gi + 1) begin : g_filt
      axr_filter #(
        .LEN (FILT_LEN)
      ) u_filt (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .din    (raw_in[gi]),
        .dout_r (filt_out[gi])
      );
    end
  endgenerate

  // costs a few cycles of latency, but one glitch cannot switch off
  assign bat_low_f = filt_out[0];
  assign oc_f      = filt_out[1];
  assign uv_f      = filt_out[2];

  ////////////////////////////////////////////////////////////////////////////
  // configuration lock; rst is power-on only, soft reset leaves it alone
  always @* begin
    cfg_nxt  = cfg_state_r;
    fail_nxt = 1'b0;
    if (cfg_wr) begin
      case (cfg_state_r)
        ST_NONE: begin
          if (aux_load_share_enable) begin
            cfg_nxt = ST_SHARE;
          end else if (aux_standalone_on && m_norm) begin
            cfg_nxt = ST_ALONE;
          end
        end
        ST_ALONE: begin
          // share request dropped quietly, no fail flag
          cfg_nxt = ST_ALONE;
        end
        ST_SHARE: begin
          if (!aux_load_share_enable || aux_standalone_on) begin
            fail_nxt = 1'b1;
          end
        end
        default: begin
          cfg_nxt = ST_NONE;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cfg_state_r <= ST_NONE;
      spi_fail_r  <= 1'b0;
    end else if (ce) begin
      cfg_state_r <= cfg_nxt;
      spi_fail_r  <= fail_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control bits; soft reset clears on and both keep bits, but not share, select or the lock
  always @(posedge clk) begin
    if (rst) begin
      on_r        <= 1'b0;
      share_r     <= 1'b0;
      sel_r       <= `AXR_LEVEL_3V3;
      keep_stop_r <= 1'b0;
      keep_uv_r   <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        on_r        <= 1'b0;
        keep_stop_r <= 1'b0;
        keep_uv_r   <= 1'b0;
      end else if (cfg_wr) begin
        // on bit only acts in normal mode, keeps value elsewhere
        if (m_norm && cfg_nxt != ST_SHARE) begin
          on_r <= aux_standalone_on;
        end
        // stays set through stop so sharing resumes in normal
        if (cfg_nxt == ST_SHARE) begin
          share_r <= 1'b1;
        end
        if (cfg_nxt != ST_SHARE) begin
          sel_r <= aux_voltage_select;
        end
        keep_stop_r <= aux_share_keep_in_stop;
        keep_uv_r   <= aux_keep_on_supply_low;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable by mode and configuration
  always @* begin
    en_nxt = 1'b0;
    if (is_sa) begin
      // undefined mode codes fall through to off
      if (m_init || m_fs) begin
        en_nxt = 1'b0;
      end else if (m_norm || m_stop || m_sleep || m_rst) begin
        en_nxt = on_r;
      end
    end else if (is_ls && share_r) begin
      if (m_norm || m_rst) begin
        en_nxt = 1'b1;
      end else if (m_stop) begin
        en_nxt = keep_stop_r;
      end else if (m_fs) begin
        en_nxt = 1'b0;
      end else if (m_sleep || m_init) begin
        en_nxt = 1'b0;
      end
    end
    // supply low switches off unless told to stay on
    if (bat_low_f && !keep_uv_r) begin
      en_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive path choice: hysteresis in stop, high only in normal
  always @* begin
    path_nxt = path_r;
    if (m_stop) begin
      if (base_above_upper) begin
        path_nxt = `AXR_PATH_HIGH;
      end else if (base_below_lower) begin
        path_nxt = `AXR_PATH_LOW;
      end
    end else begin
      path_nxt = `AXR_PATH_HIGH;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      path_r         <= `AXR_PATH_HIGH;
      reg_enable_r   <= 1'b0;
      level_1v8_r    <= `AXR_LEVEL_3V3;
      high_path_en_r <= 1'b0;
      low_path_en_r  <= 1'b0;
    end else if (ce) begin
      path_r       <= path_nxt;
      reg_enable_r <= en_nxt;
      // sharing always runs at 3.3 V; select bit ignored
      level_1v8_r  <= is_sa ? sel_r : `AXR_LEVEL_3V3;
      high_path_en_r <= en_nxt && (path_nxt == `AXR_PATH_HIGH);
      // low path idles in normal so only high path runs there
      low_path_en_r  <= en_nxt && m_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; sharing holds both at zero
  axr_sticky_flag u_oc_flag (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .set_ev (is_sa && reg_enable_r && oc_f),
    .cause  (oc_f),
    .clr    (oc_clr),
    .block  (is_ls),
    .flag_r (aux_overcurrent_flag)
  );

  axr_sticky_flag u_uv_flag (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .set_ev (is_sa && reg_enable_r && uv_f),
    .cause  (1'b0),
    .clr    (uv_clr),
    .block  (is_ls),
    .flag_r (aux_undervoltage_flag)
  );

endmodule
`default_nettype wire

/* dv/axr_ctrl_asserts.sv */
// port assertions for the auxiliary regulator control block
`include "axr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module axr_ctrl_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [2:0] op_mode,
  input wire logic       cfg_wr,
  input wire logic       aux_standalone_on,
  input wire logic       aux_load_share_enable,
  input wire logic [1:0] cfg_state_r,
  input wire logic       reg_enable_r,
  input wire logic       level_1v8_r,
  input wire logic       low_path_en_r,
  input wire logic       spi_fail_r,
  input wire logic       aux_overcurrent_flag,
  input wire logic       aux_undervoltage_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_ok = cfg_wr && ce;
  wire logic shr = cfg_state_r == `AXR_CFG_SHARE;
  sequence s_off_mode;
    (ce && (op_mode == `AXR_MODE_INIT || op_mode == `AXR_MODE_FAILSAFE))[*3];
  endsequence
  sequence s_normal;
    (ce && op_mode == `AXR_MODE_NORMAL)[*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_lock_held: assert property (
    cfg_state_r != `AXR_CFG_NONE |=> $stable(cfg_state_r))
    else $error("configuration lock moved");
  a_lock_alone: assert property (
    wr_ok && aux_standalone_on && !aux_load_share_enable &&
    op_mode == `AXR_MODE_NORMAL && cfg_state_r == `AXR_CFG_NONE
    |=> cfg_state_r == `AXR_CFG_STANDALONE)
    else $error("stand-alone not locked");
  a_lock_share: assert property (
    wr_ok && aux_load_share_enable && cfg_state_r == `AXR_CFG_NONE
    |=> shr) else $error("sharing not locked");
  a_share_fail: assert property (
    shr && wr_ok && (!aux_load_share_enable || aux_standalone_on)
    |=> spi_fail_r) else $error("no fail pulse on sharing change");
  a_alone_quiet: assert property (
    cfg_state_r == `AXR_CFG_STANDALONE && wr_ok |=> !spi_fail_r)
    else $error("fail pulse in stand-alone");
  a_share_flags: assert property (
    shr |-> !aux_overcurrent_flag && !aux_undervoltage_flag)
    else $error("flag raised while sharing");
  a_share_level: assert property (
    shr ##1 shr |-> !level_1v8_r) else $error("sharing level not 3.3 V");
  a_off_modes: assert property (
    s_off_mode |-> !reg_enable_r) else $error("enabled in init or fail-safe");
  a_normal_high: assert property (
    s_normal |-> !low_path_en_r) else $error("low path on in normal");
endmodule
bind axr_ctrl axr_ctrl_chk u_chk (
  .clk                   (clk),
  .rst                   (rst),
  .ce                    (ce),
  .op_mode               (op_mode),
  .cfg_wr                (cfg_wr),
  .aux_standalone_on     (aux_standalone_on),
  .aux_load_share_enable (aux_load_share_enable),
  .cfg_state_r           (cfg_state_r),
  .reg_enable_r          (reg_enable_r),
  .level_1v8_r           (level_1v8_r),
  .low_path_en_r         (low_path_en_r),
  .spi_fail_r            (spi_fail_r),
  .aux_overcurrent_flag  (aux_overcurrent_flag),
  .aux_undervoltage_flag (aux_undervoltage_flag)
);
`default_nettype wire

/* dv/axr_pnp_model.sv */
// pass transistor and shunt seen from the control block
`timescale 1ns/100ps
`default_nettype none
module axr_pnp_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic       overload,
  input  wire logic       sag,
  input  wire logic [1:0] load,
  output var  logic       shunt_over,
  output var  logic       aux_out_low,
  output var  logic       above_up,
  output var  logic       below_lo
);
  // no base current flows while the regulator is off
  always @(posedge clk) begin
    shunt_over <= en & overload;
    aux_out_low <= en & sag;
    above_up <= en & (load == 2'h2);
    below_lo <= !en | (load == 2'h0);
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the auxiliary regulator control block
`include "axr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk = 0, rst = 1, srst = 0, ce = 1, wr = 0, on = 0, sh = 0;
  logic       vs = 0, ks = 0, ku = 0, bl = 0, ocl = 0, ucl = 0;
  logic       ovl = 0, sag = 0, so, ol, au, bw, en, lv, hp, lp, sf, ocf, uvf;
  logic [2:0] md = `AXR_MODE_INIT;
  logic [1:0] ld = 0, cs;
  logic       fail_seen;
  int         fail_count = 0, checked = 0;
  localparam int P_OC = 0, P_UV = 1, P_SR = 2;
  always #2.5 clk = ~clk;
  axr_ctrl DUT (.clk(clk), .rst(rst), .soft_rst(srst), .ce(ce),
    .op_mode(md), .cfg_wr(wr), .aux_standalone_on(on),
    .aux_load_share_enable(sh), .aux_voltage_select(vs),
    .aux_share_keep_in_stop(ks), .aux_keep_on_supply_low(ku),
    .battery_low(bl), .shunt_over(so), .aux_out_low(ol),
    .base_above_upper(au), .base_below_lower(bw), .oc_clr(ocl),
    .uv_clr(ucl), .cfg_state_r(cs), .reg_enable_r(en), .level_1v8_r(lv),
    .high_path_en_r(hp), .low_path_en_r(lp), .spi_fail_r(sf),
    .aux_overcurrent_flag(ocf), .aux_undervoltage_flag(uvf));
  axr_pnp_model u_pnp (.clk(clk), .en(en), .overload(ovl), .sag(sag),
    .load(ld), .shunt_over(so), .aux_out_low(ol), .above_up(au),
    .below_lo(bw));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [1:0] s, input logic [1:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic st;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // config written first after power-up
  task automatic cw(input logic o, h, v, k, u);
    @(posedge clk);
    wr <= 1;
    on <= o;
    sh <= h;
    vs <= v;
    ks <= k;
    ku <= u;
    @(posedge clk);
    wr <= 0;
    #1 fail_seen = sf;
  endtask
  task automatic mode(input logic [2:0] m, input logic e);
    @(posedge clk);
    md <= m;
    st;
    chk("enable", en, e);
  endtask
  // one-cycle strobe on the clear or soft reset input
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      P_OC: ocl <= 1;
      P_UV: ucl <= 1;
      default: srst <= 1;
    endcase
    @(posedge clk);
    ocl <= 0;
    ucl <= 0;
    srst <= 0;
    st;
  endtask
  task automatic pwr;
    @(posedge clk);
    rst <= 1;
    md <= `AXR_MODE_NORMAL;
    repeat (20) @(posedge clk);
    rst <= 0;
    #1 chk("lock", cs, `AXR_CFG_NONE);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_alone;
    cw(1, 0, 1, 0, 0);
    st;
    chk("lock", cs, `AXR_CFG_STANDALONE);
    chk("level", lv, 1);
    chk("high", {lp, hp}, 2'h1);
    cw(1, 0, 0, 0, 0);
    st;
    chk("level", lv, 0);
    cw(1, 1, 0, 0, 0);
    chk("fail", fail_seen, 0);
    chk("lock", cs, `AXR_CFG_STANDALONE);
    cw(0, 0, 0, 0, 0);
    st;
    chk("off", en, 0);
    cw(1, 0, 0, 0, 0);
    mode(`AXR_MODE_STOP, 1);
    chk("low", lp, 1);
    @(posedge clk);
    ld <= 2;
    st;
    chk("high", hp, 1);
    @(posedge clk);
    ld <= 0;
    st;
    chk("high", hp, 0);
    mode(`AXR_MODE_SLEEP, 1);
    mode(`AXR_MODE_RESTART, 1);
    mode(`AXR_MODE_INIT, 0);
    mode(`AXR_MODE_NORMAL, 1);
    @(posedge clk);
    ovl <= 1;
    sag <= 1;
    st;
    chk("flags", {ocf, uvf}, 2'h3);
    pulse(P_OC);
    chk("oc", ocf, 1);
    // clear only counts once the filtered cause has gone
    @(posedge clk);
    ovl <= 0;
    sag <= 0;
    st;
    pulse(P_OC);
    pulse(P_UV);
    chk("flags", {ocf, uvf}, 2'h0);
    @(posedge clk);
    bl <= 1;
    st;
    chk("uv off", en, 0);
    @(posedge clk);
    bl <= 0;
    st;
    chk("uv on", en, 1);
    pulse(P_SR);
    chk("lock", cs, `AXR_CFG_STANDALONE);
  endtask
  task automatic t_share;
    // level select latched while unlocked, must be ignored once sharing
    cw(0, 0, 1, 0, 0);
    cw(0, 1, 0, 0, 0);
    st;
    chk("lock", cs, `AXR_CFG_SHARE);
    chk("level", {lv, en}, 2'h1);
    cw(1, 1, 0, 0, 0);
    chk("fail", fail_seen, 1);
    chk("lock", cs, `AXR_CFG_SHARE);
    mode(`AXR_MODE_STOP, 0);
    mode(`AXR_MODE_NORMAL, 1);
    cw(0, 1, 0, 1, 1);
    mode(`AXR_MODE_STOP, 1);
    mode(`AXR_MODE_SLEEP, 0);
    mode(`AXR_MODE_RESTART, 1);
    mode(`AXR_MODE_FAILSAFE, 0);
    mode(`AXR_MODE_NORMAL, 1);
    @(posedge clk);
    ovl <= 1;
    sag <= 1;
    bl <= 1;
    st;
    chk("flags", {ocf, uvf}, 2'h0);
    chk("keep", en, 1);
  endtask
  // clock enable low: mode change and write must both be held off
  task automatic t_hold;
    @(posedge clk);
    ce <= 0;
    md <= `AXR_MODE_FAILSAFE;
    st;
    chk("frozen", en, 1);
    cw(0, 0, 0, 0, 0);
    chk("fail", fail_seen, 0);
    chk("lock", cs, `AXR_CFG_SHARE);
    @(posedge clk);
    ce <= 1;
    st;
    chk("fs off", en, 0);
    chk("lock", cs, `AXR_CFG_SHARE);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    pwr;
    t_alone;
    pwr;
    t_share;
    t_hold;
    close_out;
  end
  // run needs well under 2000 cycles
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
